// ==== logic/tcc_timer.sv ====
// Purpose: 16-bit type C timer with its control word, behind an AXI4-Lite slave
// Assumes: one write and one read at most in flight; ext_count_input asynchronous
// Notes: internal instruction clock is aclk; idle and wide mode come from a system register
// Operation
// - run bit 15 starts and stops counting
// - idle-halt bit 13 stops counting in idle
// - gate bit 6 gates time, internal source only
// - divider codes give 1, 8, 64, 256
// - wide mode disables run, gate, divider, source
// - gated mode counts while high, interrupts on fall
// - external count input always synchronised
// - prescaler clears on control or count write, run clear, reset
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module tcc_timer
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External count or gate pin
	input wire logic ext_count_input,
	// Interrupt
	output logic irq
);
	import tcc_pkg::*;

	function automatic logic [7:0] div_limit(input logic [1:0] sel);
		logic [7:0] lim;
		lim = TCC_DIV_1;
		unique case (sel)
			2'b00: lim = TCC_DIV_1;
			2'b01: lim = TCC_DIV_8;
			2'b10: lim = TCC_DIV_64;
			2'b11: lim = TCC_DIV_256;
		endcase
		return lim;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = d[7:0];
		end
		if (be[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	tcc_ctrl_s ctrl, next_ctrl;
	tcc_sys_s sys, next_sys;
	logic [15:0] count, next_count;
	logic [15:0] period, next_period;
	logic [7:0] presc, next_presc;
	logic [TCC_NUM_EV-1:0] status, next_status;
	logic [TCC_NUM_EV-1:0] irq_en, next_irq_en;
	logic [TCC_NUM_EV-1:0] events;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic pin_level, pin_rise, pin_fall;
	logic do_write;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic active;
	logic tick_in;
	logic presc_out;
	logic ctrl_wr, count_wr;
	tcc_mode_e mode;

	// Pin passes two flops before any use
	tcc_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(ext_count_input),
		.level(pin_level),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// Write channel
	assign s_axi_awready = ~aw_held & ~bvalid;
	assign s_axi_wready = ~w_held & ~bvalid;
	assign wa = aw_held ? aw_addr : s_axi_awaddr;
	assign wd = w_held ? w_data : s_axi_wdata;
	assign ws = w_held ? w_strb : s_axi_wstrb;
	assign do_write = (aw_held | (s_axi_awvalid & s_axi_awready)) & (w_held | (s_axi_wvalid & s_axi_wready));
	assign ctrl_wr = do_write && wa == TCC_OFS_CTRL;
	assign count_wr = do_write && wa == TCC_OFS_COUNT;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			unique case (wa)
				TCC_OFS_CTRL, TCC_OFS_COUNT, TCC_OFS_PERIOD, TCC_OFS_IRQ_EN, TCC_OFS_IRQ_CLR,
				TCC_OFS_SYS: next_bresp = TCC_RESP_OKAY;
				TCC_OFS_STATUS: next_bresp = TCC_RESP_OKAY;
				default: next_bresp = TCC_RESP_SLVERR;
			endcase
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	// Register updates and counting
	always_comb begin
		logic [15:0] cw;
		cw = TCC_CTRL_RESET;
		next_ctrl = ctrl;
		next_sys = sys;
		next_period = period;
		next_irq_en = irq_en;
		if (ctrl_wr) begin
			cw = merge16({ctrl.run, 1'b0, ctrl.idle_halt, 6'h00, ctrl.gate_accumulate,
				ctrl.input_divider_select, 2'b00, ctrl.count_source_select, 1'b0}, wd, ws) & TCC_CTRL_WMASK;
			next_ctrl.run = cw[TCC_POS_RUN];
			next_ctrl.idle_halt = cw[TCC_POS_IDLE_HALT];
			next_ctrl.gate_accumulate = cw[TCC_POS_GATE];
			next_ctrl.input_divider_select = cw[TCC_POS_DIV_LO +: 2];
			next_ctrl.count_source_select = cw[TCC_POS_SRC];
		end
		if (do_write && wa == TCC_OFS_PERIOD) begin
			next_period = merge16(period, wd, ws);
		end
		if (do_write && wa == TCC_OFS_IRQ_EN && ws[0]) begin
			next_irq_en = wd[TCC_NUM_EV-1:0];
		end
		if (do_write && wa == TCC_OFS_SYS && ws[0]) begin
			next_sys.idle = wd[TCC_POS_SYS_IDLE];
			next_sys.pair_wide_mode = wd[TCC_POS_SYS_WIDE];
		end
	end

	always_comb begin
		if (ctrl.count_source_select) begin
			mode = TCC_MODE_COUNTER;
		end else if (ctrl.gate_accumulate) begin
			mode = TCC_MODE_GATED;
		end else begin
			mode = TCC_MODE_TIMER;
		end
	end

	// Wide mode stops this half; no control bit, idle-halt included, is still honoured
	assign active = ctrl.run & ~sys.pair_wide_mode & ~(sys.idle & ctrl.idle_halt);

	always_comb begin
		unique case (mode)
			TCC_MODE_TIMER: tick_in = 1'b1;
			TCC_MODE_GATED: tick_in = pin_level;
			TCC_MODE_COUNTER: tick_in = pin_rise;
			default: tick_in = 1'b0;
		endcase
	end

	assign presc_out = active && tick_in && presc == div_limit(ctrl.input_divider_select);

	always_comb begin
		next_presc = presc;
		next_count = count;
		events = '0;
		if (active && tick_in) begin
			next_presc = presc_out ? 8'h00 : presc + 8'h01;
		end
		if (presc_out) begin
			if (count == period) begin
				next_count = 16'h0000;
				events[TCC_EV_MATCH] = 1'b1;
			end else begin
				next_count = count + 16'h0001;
			end
		end
		if (active && mode == TCC_MODE_GATED && pin_fall) begin
			events[TCC_EV_GATE_FALL] = 1'b1;
		end
		if (ctrl_wr || count_wr || (ctrl.run && !next_ctrl.run)) begin
			next_presc = 8'h00;
		end
		if (count_wr) begin
			next_count = merge16(count, wd, ws);
		end
		// Set wins over a clear in the same cycle
		next_status = status;
		if (do_write && wa == TCC_OFS_IRQ_CLR && ws[0]) begin
			next_status = status & ~wd[TCC_NUM_EV-1:0];
		end
		next_status = next_status | events;
	end

	assign irq = |(status & irq_en);

	// Read channel
	assign s_axi_arready = ~rvalid;

	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = TCC_RESP_OKAY;
			next_rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				TCC_OFS_CTRL: next_rdata = {16'h0000, ctrl.run, 1'b0, ctrl.idle_halt, 6'h00,
					ctrl.gate_accumulate, ctrl.input_divider_select, 2'b00, ctrl.count_source_select, 1'b0};
				TCC_OFS_COUNT: next_rdata = {16'h0000, count};
				TCC_OFS_PERIOD: next_rdata = {16'h0000, period};
				TCC_OFS_STATUS: next_rdata = {30'h0000_0000, status};
				TCC_OFS_IRQ_EN: next_rdata = {30'h0000_0000, irq_en};
				TCC_OFS_IRQ_CLR: next_rdata = 32'h0000_0000;
				TCC_OFS_SYS: next_rdata = {30'h0000_0000, sys.pair_wide_mode, sys.idle};
				default: next_rresp = TCC_RESP_SLVERR;
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= '0;
			sys <= '0;
			count <= 16'h0000;
			period <= TCC_PERIOD_RESET;
			presc <= 8'h00;
			status <= '0;
			irq_en <= '0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= TCC_RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= TCC_RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			ctrl <= next_ctrl;
			sys <= next_sys;
			count <= next_count;
			period <= next_period;
			presc <= next_presc;
			status <= next_status;
			irq_en <= next_irq_en;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end
endmodule

// ==== logic/tcc_pkg.sv ====
// Purpose: shared constants and types for the type C timer control block
// Assumes: AXI4-Lite register access, 32-bit data, aligned words
// Notes: register offsets are byte addresses
package tcc_pkg;
	localparam logic [7:0] TCC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TCC_OFS_COUNT = 8'h04;
	localparam logic [7:0] TCC_OFS_PERIOD = 8'h08;
	localparam logic [7:0] TCC_OFS_STATUS = 8'h0C;
	localparam logic [7:0] TCC_OFS_IRQ_EN = 8'h10;
	localparam logic [7:0] TCC_OFS_IRQ_CLR = 8'h14;
	localparam logic [7:0] TCC_OFS_SYS = 8'h18;
	localparam int TCC_POS_RUN = 15;
	localparam int TCC_POS_IDLE_HALT = 13;
	localparam int TCC_POS_GATE = 6;
	localparam int TCC_POS_DIV_LO = 4;
	localparam int TCC_POS_SRC = 1;
	localparam logic [15:0] TCC_CTRL_WMASK = 16'hA072;
	localparam logic [15:0] TCC_CTRL_RESET = 16'h0000;
	localparam logic [15:0] TCC_PERIOD_RESET = 16'hFFFF;
	localparam int TCC_POS_SYS_IDLE = 0;
	localparam int TCC_POS_SYS_WIDE = 1;
	localparam int TCC_EV_MATCH = 0;
	localparam int TCC_EV_GATE_FALL = 1;
	localparam int TCC_NUM_EV = 2;
	localparam logic [1:0] TCC_RESP_OKAY = 2'b00;
	localparam logic [1:0] TCC_RESP_SLVERR = 2'b10;
	localparam logic [7:0] TCC_DIV_1 = 8'h00;
	localparam logic [7:0] TCC_DIV_8 = 8'h07;
	localparam logic [7:0] TCC_DIV_64 = 8'h3F;
	localparam logic [7:0] TCC_DIV_256 = 8'hFF;

	typedef struct packed {
		logic run;
		logic idle_halt;
		logic gate_accumulate;
		logic [1:0] input_divider_select;
		logic count_source_select;
	} tcc_ctrl_s;

	typedef struct packed {
		logic idle;
		logic pair_wide_mode;
	} tcc_sys_s;

	typedef enum logic [1:0] {
		TCC_MODE_TIMER = 2'b00,
		TCC_MODE_GATED = 2'b01,
		TCC_MODE_COUNTER = 2'b10
	} tcc_mode_e;
endpackage

// ==== logic/tcc_sync.sv ====
// Purpose: two-stage synchroniser with edge pulses on the stable stage
// Assumes: input is asynchronous to aclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module tcc_sync (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin side
	input wire logic async_in,
	// Synchronised side
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta;
	logic stable;
	logic last;
	logic next_meta;
	logic next_stable;
	logic next_last;

	always_comb begin
		next_meta = async_in;
		next_stable = meta;
		next_last = stable;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 1'b0;
			stable <= 1'b0;
			last <= 1'b0;
		end else begin
			meta <= next_meta;
			stable <= next_stable;
			last <= next_last;
		end
	end

	assign level = stable;
	assign rise = stable & ~last;
	assign fall = ~stable & last;
endmodule

// ==== tb/tcc_pin_src.sv ====
// Purpose: pin source for count pulses and gate levels
// Assumes: widths of two clocks or more
// Notes: rests low between bursts
`timescale 1ns/1ps
module tcc_pin_src (
	// Clock
	input wire logic aclk,
	// Pin
	output logic pin
);
	initial pin = 1'b0;
	task automatic pulses(input int n, input int w);
		repeat (n) begin
			@(posedge aclk);
			pin <= 1'b1;
			repeat (w) @(posedge aclk);
			pin <= 1'b0;
			repeat (w) @(posedge aclk);
		end
	endtask
endmodule

// ==== tb/tcc_timer_asserts.sv ====
// Purpose: bus and control word checks
// Assumes: top ports only
// Notes: bound at the foot
`timescale 1ns/1ps
module tcc_timer_asserts (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	input wire logic irq
);
	import tcc_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response moved");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	chk_write_answer: assert property (s_wr |=> s_axi_bvalid) else $error("no write response");
	chk_read_answer: assert property (s_rd |=> s_axi_rvalid) else $error("no read data");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	chk_ctrl_unused: assert property ((s_rd ##0 (s_axi_araddr == TCC_OFS_CTRL)) |=>
		(s_axi_rdata & ~{16'h0000, TCC_CTRL_WMASK}) == 32'h0) else $error("unused bit set");
	chk_wr_unmapped: assert property ((s_wr ##0 (s_axi_awaddr > TCC_OFS_SYS)) |=>
		s_axi_bresp == TCC_RESP_SLVERR) else $error("unmapped write accepted");
	chk_rd_unmapped: assert property ((s_rd ##0 (s_axi_araddr > TCC_OFS_SYS)) |=>
		s_axi_rresp == TCC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("busy after reset");
endmodule
bind tcc_timer tcc_timer_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

// ==== tb/tb_type_c_timer_control.sv ====
// Purpose: self-checking bench for tcc_timer
// Assumes: pin driven by tcc_pin_src
// Notes: expected counts are exact to the cycle
`timescale 1ns/1ps
module tb_type_c_timer_control;
	import tcc_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, pin;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rv, d;
	int seed = 32'h42FC;
	int mismatches = 0;
	int checks = 0;
	int n;
	always #2.5 aclk = ~aclk;
	tcc_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_count_input(pin), .irq(irq));
	tcc_pin_src src (.aclk(aclk), .pin(pin));
	function automatic int shf(int k);
		return (k == 3) ? 8 : 3 * k;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rv = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic run(input logic [31:0] c, input int cyc);
		wr(TCC_OFS_COUNT, 32'h0);
		wr(TCC_OFS_CTRL, c);
		repeat (cyc) @(posedge aclk);
		wr(TCC_OFS_CTRL, 32'h0);
		rd(TCC_OFS_COUNT);
	endtask
	task automatic pin_run(input logic [31:0] c, input int k, input int w);
		wr(TCC_OFS_COUNT, 32'h0);
		wr(TCC_OFS_CTRL, c);
		src.pulses(k, w);
		repeat (6) @(posedge aclk);
		wr(TCC_OFS_CTRL, 32'h0);
		rd(TCC_OFS_COUNT);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		print_verdict;
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(TCC_OFS_CTRL);
		chk("ctrl reset", rv, 32'h0);
		rd(TCC_OFS_PERIOD);
		chk("period reset", rv, 32'h0000FFFF);
		repeat (6) begin
			d = $random(seed);
			wr(TCC_OFS_CTRL, d);
			rd(TCC_OFS_CTRL);
			chk("ctrl bits", rv, d & {16'h0000, TCC_CTRL_WMASK});
		end
		wr(8'h40, d);
		chk("wr resp", rsp, TCC_RESP_SLVERR);
		rd(8'h40);
		chk("rd resp", rsp, TCC_RESP_SLVERR);
		// Stop the random control word before timed runs
		wr(TCC_OFS_CTRL, 32'h0);
		$display("test registers done");
		for (int k = 0; k < 4; k++) begin
			run(32'h8000 | (k << 4), 1024);
			chk("divided count", rv, 1027 >> shf(k));
		end
		// Rewrite within one prescale span
		wr(TCC_OFS_COUNT, 32'h0);
		wr(TCC_OFS_CTRL, 32'h8020);
		repeat (40) @(posedge aclk);
		run(32'h8020, 40);
		chk("prescale clear", rv, 32'h0);
		for (int k = 0; k < 3; k++) begin
			wr(TCC_OFS_SYS, (k == 2) ? 32'h2 : 32'h1);
			run((k == 0) ? 32'hA000 : 32'h8000, 64);
			chk("idle wide", rv, (k == 1) ? 67 : 0);
		end
		wr(TCC_OFS_SYS, 32'h0);
		$display("test timing done");
		n = 1 + ($unsigned($random(seed)) % 8);
		pin_run(32'h8042, n, 3);
		chk("edge count", rv, n);
		pin_run(32'h8040, 4, 5);
		chk("gated count", rv, 20);
		rd(TCC_OFS_STATUS);
		chk("gate fall", rv, 32'h2);
		wr(TCC_OFS_IRQ_EN, 32'h2);
		chk("irq on", irq, 1'b1);
		wr(TCC_OFS_IRQ_EN, 32'h0);
		chk("irq masked", irq, 1'b0);
		wr(TCC_OFS_IRQ_EN, 32'h3);
		wr(TCC_OFS_IRQ_CLR, 32'h2);
		chk("irq cleared", irq, 1'b0);
		wr(TCC_OFS_PERIOD, 32'h3);
		run(32'h8000, 20);
		chk("irq match", irq, 1'b1);
		rd(TCC_OFS_STATUS);
		chk("match status", rv, 32'h1);
		$display("test pin and irq done");
		print_verdict;
	end
endmodule
